//--- design/por_delay_cfg.svh
// constants for the power-on reset delay block
//----------------------------------------------------------------------
// Contract
// - on power-up, set reset latch (chip reset on) and clear delay timer.
// - timer stays idle while master clear is low; counts once it is high.
// - at timer time-out (about 18 ms) clear the latch, release chip reset.
// - a falling supply never asserts reset; only a rising supply does.
//----------------------------------------------------------------------
`ifndef POR_DELAY_CFG_SVH
`define POR_DELAY_CFG_SVH

// nominal time-out in microseconds
`define RESET_DELAY_PERIOD_US 18000
// time base frequency in MHz
`define TIME_BASE_MHZ 50
// cycles of time base for the whole delay
`define RESET_DELAY_CYCLES (`RESET_DELAY_PERIOD_US * `TIME_BASE_MHZ)
// width of the delay counter
`define DELAY_CNT_W 20
// counter value after clear
`define DELAY_CNT_RESET 20'h00000
// supply history after rst: present, so no false rise follows reset
`define SUPPLY_SEEN_RESET 1'b1

`endif

//--- design/por_delay_pkg.sv
// types shared by the power-on reset delay block
package por_delay_pkg;
	typedef enum logic [1:0] {
		ST_HELD = 2'b00,
		ST_COUNT = 2'b01,
		ST_RUN = 2'b11
	} seq_state_t;
endpackage

//--- design/delay_if.sv
// link between sequencer and delay timer
`timescale 1ns/10ps
interface delay_if;
	logic clear;
	logic enable;
	logic expired;
	modport seq(output clear, output enable, input expired);
	modport tmr(input clear, input enable, output expired);
endinterface

//--- design/reset_delay_timer.sv
// reset delay timer counting on the on-chip time base
`timescale 1ns/10ps
`include "por_delay_cfg.svh"
module reset_delay_timer
	import por_delay_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = `RESET_DELAY_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	delay_if.tmr ctl
);
	localparam logic [`DELAY_CNT_W-1:0] LAST = `DELAY_CNT_W'(DELAY_CYCLES - 1);
	logic [`DELAY_CNT_W-1:0] count;
	wire at_last = (count == LAST);

	//------------------------------------------------------------------
	// counter
	//------------------------------------------------------------------
	// clear dominates so a fresh power-up restarts the whole delay
	always_ff @(posedge clk) begin
		if (rst || ctl.clear) begin
			count <= `DELAY_CNT_RESET;
		end else if (ctl.enable && !at_last) begin
			count <= count + `DELAY_CNT_W'(1);
		end
	end

	assign ctl.expired = ctl.enable && at_last;

	a_hold_when_idle: assert property (@(posedge clk) disable iff (rst)
		!ctl.enable && !ctl.clear |=> count == $past(count))
		else $error("delay counter moved while idle");
endmodule // reset_delay_timer

//--- design/power_on_reset_delay.sv
// power-on reset sequencer: reset latch plus start-up delay
`timescale 1ns/10ps
`include "por_delay_cfg.svh"
module power_on_reset_delay
	import por_delay_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = `RESET_DELAY_CYCLES
) (
	input wire logic clk, // on-chip time base, independent of main osc
	input wire logic rst,
	input wire logic power_up, // level from supply detector, high when supply present
	input wire logic master_clear_n,
	output logic chip_reset,
	output logic delay_running
);
	seq_state_t state;
	seq_state_t next_state;
	logic supply_seen;
	delay_if link();

	//------------------------------------------------------------------
	// supply edge detection
	//------------------------------------------------------------------
	// only a rising supply counts; a falling one is ignored on purpose
	always_ff @(posedge clk) begin
		if (rst) begin
			supply_seen <= `SUPPLY_SEEN_RESET;
		end else begin
			supply_seen <= power_up;
		end
	end
	wire supply_rise = power_up && !supply_seen;

	//------------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------------
	// master clear low with no fresh power-up parks the timer where it is
	always_comb begin
		next_state = state;
		unique case (state)
			ST_HELD: begin
				if (master_clear_n) begin
					next_state = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (link.expired) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: next_state = ST_RUN;
			default: next_state = ST_HELD;
		endcase
		if (supply_rise) begin
			next_state = ST_HELD;
		end
	end

	// rst stands in for the very first power-up
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_HELD;
		end else begin
			state <= next_state;
		end
	end

	// output flops; latch set on power-up, cleared on time-out
	always_ff @(posedge clk) begin
		if (rst) begin
			chip_reset <= 1'b1;
			delay_running <= 1'b0;
		end else begin
			chip_reset <= (next_state != ST_RUN);
			delay_running <= (next_state == ST_COUNT);
		end
	end

	assign link.clear = supply_rise;
	// limitation: master clear dropping mid-count pauses rather than restarts
	assign link.enable = (state == ST_COUNT) && master_clear_n && !supply_rise;

	reset_delay_timer #(
		.DELAY_CYCLES(DELAY_CYCLES)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.ctl(link)
	);

	//------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------
	sequence s_powered;
		power_up && !supply_seen;
	endsequence

	a_rise_sets_reset: assert property (@(posedge clk) disable iff (rst)
		s_powered |=> chip_reset)
		else $error("power-up did not assert chip reset");

	a_fall_no_reset: assert property (@(posedge clk) disable iff (rst)
		!chip_reset && !power_up |=> !chip_reset)
		else $error("supply fall asserted reset");

	a_held_while_low: assert property (@(posedge clk) disable iff (rst)
		state == ST_HELD && !master_clear_n && !supply_rise |=> state == ST_HELD)
		else $error("left hold with master clear low");

	a_release_on_exp: assert property (@(posedge clk) disable iff (rst)
		link.expired && !supply_rise |=> !chip_reset)
		else $error("time-out did not release reset");

	a_release_cause: assert property (@(posedge clk) disable iff (rst)
		$fell(chip_reset) |-> $past(link.expired))
		else $error("reset released without time-out");

	//------------------------------------------------------------------
	// check helpers
	//------------------------------------------------------------------
	// decoded views of the sequencer, read only by the checks below
	wire in_held = (state == ST_HELD);
	wire in_count = (state == ST_COUNT);
	wire in_run = (state == ST_RUN);
	wire step_taken = link.enable; // timer advances on each high cycle except the expiry cycle, where it holds its last value

	// steps from clear to release, one bit wider than the timer so that
	// a runaway count cannot wrap back into range and hide itself
	localparam logic [`DELAY_CNT_W:0] STEPS_TO_RELEASE = (`DELAY_CNT_W+1)'(DELAY_CYCLES);
	logic [`DELAY_CNT_W:0] watch_steps;
	wire tally_empty = (watch_steps == {1'b0, `DELAY_CNT_RESET});

	// independent tally of timer steps since the last clear; it ignores
	// the timer's own end detect, so a wrong terminal count shows up here
	always_ff @(posedge clk) begin
		if (rst || supply_rise) begin
			watch_steps <= {1'b0, `DELAY_CNT_RESET};
		end else if (step_taken) begin
			watch_steps <= watch_steps + (`DELAY_CNT_W+1)'(1);
		end
	end

	//------------------------------------------------------------------
	// sequences for the multi-step checks
	//------------------------------------------------------------------
	// master clear seen high while parked, no power-up in the way
	sequence s_start_seen;
		in_held && master_clear_n && !supply_rise;
	endsequence

	// first cycle of a fresh count: nothing counted yet, chip still held
	sequence s_count_entered;
		in_count && delay_running && chip_reset && tally_empty;
	endsequence

	// count state with master clear pulled low again
	sequence s_paused;
		in_count && !master_clear_n && !supply_rise;
	endsequence

	// timer still owns the chip: counting, reset held
	sequence s_still_counting;
		in_count && chip_reset && delay_running;
	endsequence

	// released and left alone by the supply detector
	sequence s_settled_run;
		in_run && !supply_rise;
	endsequence

	// chip free to run, nothing left counting
	sequence s_released;
		!chip_reset && !delay_running;
	endsequence

	// after a power-up: parked, idle, timer not stepping
	sequence s_parked;
		in_held && !delay_running && !step_taken;
	endsequence

	//------------------------------------------------------------------
	// sequencing checks
	//------------------------------------------------------------------
	// entering the count is the only way out of the parked state
	a_start_when_high: assert property (@(posedge clk) disable iff (rst)
		s_start_seen |=> s_count_entered)
		else $error("master clear high did not start a fresh count");

	// a pause must never be taken for a time-out
	a_pause_keeps_reset: assert property (@(posedge clk) disable iff (rst)
		s_paused |=> s_still_counting)
		else $error("master clear low in count moved the sequencer");

	// power-up wins over everything, a count in flight included
	a_rise_clears_all: assert property (@(posedge clk) disable iff (rst)
		s_powered |=> s_parked)
		else $error("power-up did not park the sequencer");

	// released stays released until the supply detector re-arms
	a_run_stays_free: assert property (@(posedge clk) disable iff (rst)
		s_settled_run |=> s_released)
		else $error("released chip went back into reset without power-up");

	// the timer sits on its last value, so expiry must drop with the state
	a_single_expiry: assert property (@(posedge clk) disable iff (rst)
		link.expired |=> !link.expired)
		else $error("time-out held for more than one cycle");

	// the tally decides the period independently of the timer's compare
	a_period_exact: assert property (@(posedge clk) disable iff (rst)
		$fell(chip_reset) |-> (watch_steps == STEPS_TO_RELEASE))
		else $error("reset released after the wrong number of steps");

	// catches a counter that runs on past its compare value
	a_no_overrun: assert property (@(posedge clk) disable iff (rst)
		in_count |-> (watch_steps < STEPS_TO_RELEASE))
		else $error("timer counted past its time-out");

	// no disable here: the check is about the release of rst itself
	a_reset_state_out: assert property (@(posedge clk)
		$fell(rst) |-> chip_reset && !delay_running)
		else $error("outputs not in reset state as rst was released");
endmodule // power_on_reset_delay

//--- verif/board_model.sv
// board-side model: supply detector and master clear driver
`timescale 1ns/10ps
module board_model (
	input wire logic clk,
	input wire logic supply_on,
	input wire logic press_n,
	output logic power_up,
	output logic master_clear_n
);
	// pins follow one edge late, like a slow board network
	always @(posedge clk) begin
		power_up <= supply_on;
		master_clear_n <= press_n & supply_on;
	end
endmodule // board_model

//--- verif/power_on_reset_delay_test.sv
// testbench for the power-on reset delay block
`timescale 1ns/10ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, a); end end
module power_on_reset_delay_test;
	localparam int unsigned DLY = 16;
	logic clk = 1'b0, rst = 1'b1, supply_on = 1'b1, press_n = 1'b0;
	logic power_up, master_clear_n, chip_reset, delay_running;
	int miscompares = 0, num_checks = 0, n;
	board_model board (.clk(clk), .supply_on(supply_on), .press_n(press_n),
		.power_up(power_up), .master_clear_n(master_clear_n));
	power_on_reset_delay #(.DELAY_CYCLES(DLY)) dut (.clk(clk), .rst(rst),
		.power_up(power_up), .master_clear_n(master_clear_n),
		.chip_reset(chip_reset), .delay_running(delay_running));
	initial begin
		forever #10 clk = ~clk;
	end
	task automatic tick(int k);
		repeat (k) begin
			@(posedge clk);
			#1;
		end
	endtask
	// edges from entering the count state until reset drops, bounded
	task automatic time_release();
		n = 0;
		while (delay_running !== 1'b1 && n < 50) begin
			tick(1);
			n++;
		end
		n = 0;
		while (chip_reset === 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
	endtask
	task automatic test_held();
		tick(30);
		`CHK("chip_reset", 1'b1, chip_reset)
		`CHK("delay_running", 1'b0, delay_running)
		@(posedge clk) press_n <= 1'b1;
		time_release();
		`CHK("release_edges", DLY, n)
		`CHK("delay_running", 1'b0, delay_running)
		$display("test_held done");
	endtask
	task automatic test_supply();
		@(posedge clk) supply_on <= 1'b0;
		tick(5);
		`CHK("chip_reset", 1'b0, chip_reset)
		@(posedge clk) supply_on <= 1'b1;
		tick(3);
		`CHK("chip_reset", 1'b1, chip_reset)
		time_release();
		`CHK("release_edges", DLY, n)
		$display("test_supply done");
	endtask
	// three steps banked, a pause, then the rest: pin delay hands one edge back
	task automatic test_pause();
		@(posedge clk) supply_on <= 1'b0;
		press_n <= 1'b0;
		tick(3);
		@(posedge clk) supply_on <= 1'b1;
		tick(4);
		`CHK("chip_reset", 1'b1, chip_reset)
		`CHK("delay_running", 1'b0, delay_running)
		@(posedge clk) press_n <= 1'b1;
		tick(3);
		@(posedge clk) press_n <= 1'b0;
		tick(10);
		`CHK("chip_reset", 1'b1, chip_reset)
		`CHK("delay_running", 1'b1, delay_running)
		@(posedge clk) press_n <= 1'b1;
		time_release();
		`CHK("release_edges", DLY - 2, n)
		$display("test_pause done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// main sequence after a six-cycle reset
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		test_held();
		test_supply();
		test_pause();
		wrap_up();
	end
	// watchdog: tests need about 120 cycles
	initial begin
		#20000;
		miscompares++;
		wrap_up();
	end
endmodule // power_on_reset_delay_test
